// >>> rtl/wdt_map.vh
`ifndef WDT_MAP_VH
`define WDT_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define WDT_CONTROL_ADDR 8'hd3
`define WDT_COUNT_ADDR 8'hfd
// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define WDT_CONTROL_RESET 8'h00
`define WDT_KEY_HI 7
`define WDT_KEY_LO 4
`define WDT_SEL_HI 3
`define WDT_SEL_LO 2
`define WDT_CNT_CLR_BIT 1
`define WDT_DIV_CLR_BIT 0
`define WDT_DISABLE_KEY 4'ha
// ----------------------------------------
// prescale ratios and stabilization tap
// ----------------------------------------
`define WDT_DIV_4096 2'h0
`define WDT_DIV_1024 2'h1
`define WDT_DIV_128 2'h2
`define WDT_DIV_16 2'h3
`define WDT_DIV_WIDTH 12
`define WDT_STAB_BIT 3
`endif

// >>> rtl/wdt_prescaler.v
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.vh"
module wdt_prescaler #(
	parameter WIDTH = `WDT_DIV_WIDTH
) (
	input  wire       clk,
	input  wire       rst,
	input  wire       clear,
	input  wire [1:0] sel,
	output reg        tick
);
	reg  [WIDTH-1:0] div;
	wire [WIDTH-1:0] next_div;
	reg              wrap;

	assign next_div = div + {{(WIDTH-1){1'b0}}, 1'b1};

	// ----------------------------------------
	// tap select: a tick when the chosen low field wraps to zero
	// ----------------------------------------
	always @* begin
		case (sel)
			`WDT_DIV_4096: wrap = (next_div[11:0] == 12'h000);
			`WDT_DIV_1024: wrap = (next_div[9:0] == 10'h000);
			`WDT_DIV_128: wrap = (next_div[6:0] == 7'h00);
			`WDT_DIV_16: wrap = (next_div[3:0] == 4'h0);
			default: wrap = 1'b0;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			div <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else if (clear) begin
			div <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else begin
			div <= next_div;
			tick <= wrap;
		end
	end
endmodule // wdt_prescaler
`default_nettype wire

// >>> rtl/wdt_basic_timer.v
// Contract
// - counter clock is system clock divided by 4096, 1024, 128 or 16.
// - 8-bit count register at FDH, read only.
// - control register at D3H, readable and writable.
// - reset clears control to 00H: watchdog on, divide by 4096.
// - watchdog off only while control bits 7..4 hold 1010B.
// - writing one to control bit 1 clears the counter at once.
// - writing one to control bit 0 clears the timer dividers.
// - enabled watchdog resets the system when the counter overflows bit 7; the code resets only in ST_RUN, not during stabilization.
// - after stop ends, count at divide 4096 after reset, else preset rate.
// - hold CPU clock off until counter bit 3 overflows, then signal done.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.vh"
module wdt_basic_timer (
	input  wire       CLK,
	input  wire       SYS_RST,
	input  wire [7:0] REG_ADDR,
	input  wire       REG_WR,
	input  wire       REG_RD,
	input  wire [7:0] REG_WDATA,
	input  wire       STOP_MODE,
	input  wire       STOP_WAKE,
	output reg  [7:0] REG_RDATA,
	output reg        WDT_RESET,
	output reg        DIV_CLEAR,
	output reg        CPU_CLK_EN,
	output reg        STAB_DONE
);
	// ----------------------------------------
	// stabilization states
	// ----------------------------------------
	// leaving stop always re-runs the interval, whatever woke the part
	localparam [1:0] ST_STAB = 2'b00;
	localparam [1:0] ST_RUN  = 2'b01;
	localparam [1:0] ST_STOP = 2'b10;

	reg  [7:0] timer_control;
	reg  [7:0] next_control;
	reg  [7:0] timer_count;
	reg  [7:0] next_count;
	reg  [7:0] next_rdata;
	reg  [1:0] state;
	reg  [1:0] next_state;
	reg        stop_s1;
	reg        stop_s2;
	reg        wake_s1;
	reg        wake_s2;
	reg        wake_d;
	wire       tick;
	wire       wr_ctl;
	wire       cnt_clear;
	wire       div_clear;
	wire       wake_edge;
	wire       count_step;
	wire       wd_enabled;
	wire       overflow;
	wire       stab_ovf;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function hits;
		input       strobe;
		input [7:0] addr;
		input [7:0] target;
		begin
			hits = strobe && (addr == target);
		end
	endfunction

	// a clear bit acts only when written as one; zero is a no-op
	function one_shot;
		input         write;
		input [7:0]   data;
		input integer pos;
		begin
			one_shot = write && data[pos];
		end
	endfunction

	function key_off;
		input [7:0] ctl;
		begin
			key_off = (ctl[`WDT_KEY_HI:`WDT_KEY_LO] == `WDT_DISABLE_KEY);
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stop_s1 <= 1'b0;
			stop_s2 <= 1'b0;
			wake_s1 <= 1'b0;
			wake_s2 <= 1'b0;
			wake_d <= 1'b0;
		end else begin
			stop_s1 <= STOP_MODE;
			stop_s2 <= stop_s1;
			wake_s1 <= STOP_WAKE;
			wake_s2 <= wake_s1;
			wake_d <= wake_s2;
		end
	end

	// ----------------------------------------
	// strobes and events
	// ----------------------------------------
	assign wr_ctl = hits(REG_WR, REG_ADDR, `WDT_CONTROL_ADDR);
	assign cnt_clear = one_shot(wr_ctl, REG_WDATA, `WDT_CNT_CLR_BIT);
	assign div_clear = one_shot(wr_ctl, REG_WDATA, `WDT_DIV_CLR_BIT);
	assign wake_edge = wake_s2 && !wake_d;
	// a clear or wake in the tick cycle wins, so a clear at 0xff averts the reset
	assign count_step = tick && !stop_s2 && !cnt_clear && !wake_edge;
	assign wd_enabled = !key_off(timer_control);
	assign overflow = count_step && (timer_count == 8'hff);
	assign stab_ovf = count_step && (timer_count[`WDT_STAB_BIT:0] == 4'hf);

	// divider clear pulse also restarts the prescaler here
	wdt_prescaler #(
		.WIDTH(`WDT_DIV_WIDTH)
	) u_prescaler (
		.clk  (CLK),
		.rst  (SYS_RST),
		.clear(div_clear),
		.sel  (timer_control[`WDT_SEL_HI:`WDT_SEL_LO]),
		.tick (tick)
	);

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// clear bits are never stored, so they read back as zero
	always @* begin
		next_control = timer_control;
		if (wr_ctl)
			next_control = {REG_WDATA[7:2], 2'b00};
	end

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			timer_control <= `WDT_CONTROL_RESET;
		else
			timer_control <= next_control;
	end

	// ----------------------------------------
	// counter; frozen in stop mode since the oscillator is off
	// ----------------------------------------
	always @* begin
		next_count = timer_count;
		if (cnt_clear)
			next_count = 8'h00;
		else if (wake_edge)
			next_count = 8'h00;
		else if (count_step)
			next_count = timer_count + 8'h01;
	end

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			timer_count <= 8'h00;
		else
			timer_count <= next_count;
	end

	// ----------------------------------------
	// stabilization interval
	// ----------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_STAB: begin
				if (stop_s2)
					next_state = ST_STOP;
				else if (stab_ovf)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (stop_s2)
					next_state = ST_STOP;
			end
			ST_STOP: begin
				if (!stop_s2)
					next_state = ST_STAB;
			end
			default: begin
				next_state = ST_STAB;
			end
		endcase
	end

	// cpu clock stays gated for the whole interval after reset and after stop
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state <= ST_STAB;
			CPU_CLK_EN <= 1'b0;
			STAB_DONE <= 1'b0;
		end else begin
			state <= next_state;
			CPU_CLK_EN <= (next_state == ST_RUN);
			STAB_DONE <= (state == ST_STAB) && (next_state == ST_RUN);
		end
	end

	// ----------------------------------------
	// watchdog reset and divider pulse
	// ----------------------------------------
	// the watchdog sleeps through stabilization; the count restarts only after reset, a wake edge or a bit 1 clear write, not when stop ends alone
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			WDT_RESET <= 1'b0;
			DIV_CLEAR <= 1'b0;
		end else begin
			WDT_RESET <= overflow && wd_enabled && (state == ST_RUN);
			DIV_CLEAR <= div_clear;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always @* begin
		case (REG_ADDR)
			`WDT_CONTROL_ADDR: next_rdata = timer_control;
			`WDT_COUNT_ADDR: next_rdata = timer_count;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			REG_RDATA <= 8'h00;
		else if (REG_RD)
			REG_RDATA <= next_rdata;
	end
endmodule // wdt_basic_timer
`default_nettype wire

// >>> tb/wdt_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_monitor (
	input wire       CLK,
	input wire       SYS_RST,
	input wire [7:0] REG_ADDR,
	input wire       REG_WR,
	input wire       REG_RD,
	input wire [7:0] REG_WDATA,
	input wire       STOP_MODE,
	input wire       STOP_WAKE,
	input wire [7:0] REG_RDATA,
	input wire       WDT_RESET,
	input wire       DIV_CLEAR,
	input wire       CPU_CLK_EN,
	input wire       STAB_DONE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	wire wc = REG_WR && REG_ADDR == 8'hd3;
	wire ru = REG_RD && REG_ADDR != 8'hd3 && REG_ADDR != 8'hfd;
	reg  off;
	// own copy of the key, so a stuck control register is caught
	always @(posedge CLK or posedge SYS_RST)
		if (SYS_RST) off <= 1'h0;
		else if (wc) off <= REG_WDATA[7:4] == 4'ha;
	AST_DIV: assert property (DIV_CLEAR == $past(wc && REG_WDATA[0]))
		else $error("div");
	AST_CLR: assert property (wc && REG_WDATA[1] ##1 REG_RD && REG_ADDR == 8'hfd |=> REG_RDATA < 8'h02)
		else $error("clr");
	AST_WD: assert property (WDT_RESET |-> CPU_CLK_EN ##1 !WDT_RESET)
		else $error("wd");
	AST_KEY: assert property (off && $past(off) |-> !WDT_RESET)
		else $error("key");
	AST_STAB: assert property (STAB_DONE |-> ##[0:1] CPU_CLK_EN)
		else $error("stab");
	AST_WAKE: assert property ($rose(STOP_WAKE) |-> ##[1:4] !CPU_CLK_EN)
		else $error("wake");
	AST_MAP: assert property (ru |=> REG_RDATA == 8'h00)
		else $error("map");
	AST_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("hold");
endmodule // wdt_monitor
bind wdt_basic_timer wdt_monitor i_wdt_monitor (.*);
`default_nettype wire

// >>> tb/test_wdt_basic_timer.sv
`timescale 1ns/1ns
`default_nettype none
module test_wdt_basic_timer;
	logic       CLK = 1'h0, SYS_RST = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0, STOP_MODE = 1'h0, STOP_WAKE = 1'h0;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, ctl = 8'h00, e;
	wire  [7:0] REG_RDATA;
	wire        WDT_RESET, DIV_CLEAR, CPU_CLK_EN, STAB_DONE;
	int         num_errors = 0, n_checks = 0, cyc = 0, c0, n;
	int         r[4] = '{4096, 1024, 128, 16};
	wdt_basic_timer i_wdt_basic_timer (.*);
	always #10 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 98000) begin
			num_errors++;
			finish_test;
		end
	end
	task finish_test;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] x, y, s);
		n_checks++;
		if (s !== x && s !== y) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, x, s);
		end
	endtask
	task acc(input logic w, input logic [7:0] ad, d);
		{REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, ad, d};
		@(posedge CLK);
		#1;
		if (w && ad == 8'hd3) begin
			ctl = d & 8'hfc;
			c0 = cyc;
		end
	endtask
	task idle;
		{REG_WR, REG_RD} = 2'h0;
	endtask
	// bounded wait; one-cycle pulses are caught since we sample every cycle
	task wt(input int lim, input bit k);
		n = 0;
		while (n < lim && (k ? WDT_RESET : STAB_DONE) !== 1'h1) begin
			@(posedge CLK);
			#1;
			n++;
		end
	endtask
	initial begin
		void'($urandom(32'hc1c14d47));
		repeat (20) @(posedge CLK);
		#1;
		SYS_RST = 1'h0;
		chk("cpu_en", 8'h00, 8'h00, {7'h00, CPU_CLK_EN});
		acc(0, 8'hd3, 8'h00);
		idle;
		chk("ctl", 8'h00, 8'h00, REG_RDATA);
		wt(70000, 0);
		chk("stab", 8'h0f, 8'h10, 8'(n / 4096));
		chk("cpu_on", 8'h01, 8'h01, {7'h00, CPU_CLK_EN});
		for (int s = 0; s < 4; s++) begin
			acc(1, 8'hd3, 8'(s * 4 + 3));
			chk("div", 8'h01, 8'h01, {7'h00, DIV_CLEAR});
			acc(1, 8'hfd, 8'($urandom));
			idle;
			repeat (r[s] * 3) @(posedge CLK);
			#1;
			acc(0, 8'hd3, 8'h00);
			chk("ctl", ctl, ctl, REG_RDATA);
			acc(0, 8'hfd, 8'h00);
			idle;
			chk("cnt", 8'h03, 8'h02, REG_RDATA);
		end
		wt(4200, 1);
		chk("wdt", 8'h0f, 8'h10, 8'(n / 256));
		acc(1, 8'hd3, 8'haf);
		idle;
		wt(4400, 1);
		chk("wdt_off", 8'h01, 8'h01, 8'(n / 4400));
		acc(0, 8'hfd, 8'h00);
		idle;
		e = 8'((cyc - c0) / 16);
		chk("wrap", e, e - 8'h01, REG_RDATA);
		acc(1, 8'hd3, 8'hae);
		chk("div_off", 8'h00, 8'h00, {7'h00, DIV_CLEAR});
		acc(0, 8'hfd, 8'h00);
		idle;
		chk("clr", 8'h00, 8'h00, REG_RDATA);
		acc(0, 8'($urandom) & 8'hfe, 8'h00);
		idle;
		chk("map", 8'h00, 8'h00, REG_RDATA);
		acc(1, 8'hd3, 8'h0f);
		idle;
		STOP_MODE = 1'h1;
		repeat (8) @(posedge CLK);
		#1;
		chk("cpu_stop", 8'h00, 8'h00, {7'h00, CPU_CLK_EN});
		{STOP_MODE, STOP_WAKE} = 2'h1;
		wt(400, 0);
		chk("wake", 8'h04, 8'h03, 8'(n / 64));
		chk("cpu_wake", 8'h01, 8'h01, {7'h00, CPU_CLK_EN});
		SYS_RST = 1'h1;
		repeat (2) @(posedge CLK);
		#1;
		SYS_RST = 1'h0;
		acc(0, 8'hd3, 8'h00);
		idle;
		chk("ctl_rst", 8'h00, 8'h00, REG_RDATA);
		chk("cpu_rst", 8'h00, 8'h00, {7'h00, CPU_CLK_EN});
		finish_test;
	end
endmodule // test_wdt_basic_timer
`default_nettype wire
